/* File: include/bridge_pkg.sv */
package bridge_pkg;

    // ==================================================
    // register map, byte offsets on the register port
    localparam logic [7:0] OFS_BRIDGE_CONTROL = 8'h00;
    localparam logic [7:0] OFS_COMMAND        = 8'h04;
    localparam logic [7:0] OFS_IO_BASE        = 8'h08;
    localparam logic [7:0] OFS_IO_LIMIT       = 8'h0c;
    localparam logic [7:0] OFS_MEM_BASE       = 8'h10;
    localparam logic [7:0] OFS_MEM_LIMIT      = 8'h14;
    localparam logic [7:0] OFS_PREF_BASE      = 8'h18;
    localparam logic [7:0] OFS_PREF_LIMIT     = 8'h1c;
    localparam logic [7:0] OFS_IRQ_STATUS     = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK       = 8'h24;

    // ==================================================
    // field positions
    localparam int BC_PARITY_BIT = 0;
    localparam int BC_SYSERR_BIT = 1;
    localparam int BC_ALIAS_BIT  = 2;
    localparam int BC_VIDEO_BIT  = 3;
    localparam int BC_FULL_BIT   = 4;
    localparam int BC_W          = 5;
    localparam int CMD_IO_BIT    = 0;
    localparam int CMD_MEM_BIT   = 1;
    localparam int CMD_SERR_BIT  = 8;
    localparam int CMD_W         = 9;
    localparam int IRQ_SYSERR    = 0;
    localparam int IRQ_PARITY    = 1;
    localparam int IRQ_POISON    = 2;
    localparam int IRQ_W         = 3;

    // ==================================================
    // reset values and address constants
    localparam logic [BC_W-1:0]  BC_RESET        = 5'h00;
    localparam logic [CMD_W-1:0] CMD_RESET       = 9'h000;
    localparam logic [31:0]      WIN_BASE_RESET  = 32'hffff_ffff;
    localparam logic [31:0]      WIN_LIMIT_RESET = 32'h0000_0000;
    localparam logic [31:0]      VIDEO_MEM_LO    = 32'h000a_0000;
    localparam logic [31:0]      VIDEO_MEM_HI    = 32'h000b_ffff;
    localparam logic [9:0]       VIDEO_IO_A_LO   = 10'h3b0;
    localparam logic [9:0]       VIDEO_IO_A_HI   = 10'h3bb;
    localparam logic [9:0]       VIDEO_IO_B_LO   = 10'h3c0;
    localparam logic [9:0]       VIDEO_IO_B_HI   = 10'h3df;

    // ==================================================
    // carriers
    typedef struct packed {
        logic        valid;
        logic        is_io;
        logic [31:0] addr;
    } req_s;

    typedef struct packed {
        logic valid;
        logic forward;
    } resp_s;

endpackage : bridge_pkg

/* File: hdl/bridge_legacy_decode_error_ctrl.sv */
// Behaviour
// - full decode clear ignores io bits 15:10; set requires them zero
// - full decode bit matters only while legacy video forwarding is on
// - video forwarding on: forward downstream memory in a0000 to bffff
// - video forwarding on: forward downstream io 3b0-3bb, 3c0-3df, upper half zero
// - video forwarding on: block upstream requests to legacy video addresses
// - video forwarding ignores alias block and all base limit windows
// - video io needs io space enable, video memory needs memory space enable
// - alias block applies only inside io window and first 64 KB
// - alias block set: refuse downstream io to upper 768 bytes of 1 KB
// - alias block set: forward upstream io to upper 768 bytes of 1 KB
// - alias block clear: forward all downstream io inside io window while io space is enabled
// - forward system error only with forward bit, command enable and secondary error
// - forward bit clear: never forward secondary system errors
// - parity response clear: ignore secondary address, attribute, data errors
// - parity response set: detect and report those secondary errors
// - always poison data forwarded upstream after an uncorrectable data error
module bridge_legacy_decode_error_ctrl #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    input  wire bridge_pkg::req_s  dn_req,
    output bridge_pkg::resp_s      dn_resp,
    input  wire bridge_pkg::req_s  up_req,
    output bridge_pkg::resp_s      up_resp,
    input  wire logic              sec_serr_n,
    input  wire logic              sec_addr_err,
    input  wire logic              sec_attr_err,
    input  wire logic              sec_data_err,
    input  wire logic              up_data_valid,
    output logic                   up_data_fwd_valid,
    output logic                   up_data_poison,
    output logic                   pri_syserr,
    output logic                   parity_err_report,
    output logic                   irq
);

    // ==================================================
    // state
    typedef struct packed {
        logic [bridge_pkg::BC_W-1:0]  bc;
        logic [bridge_pkg::CMD_W-1:0] cmd;
        logic [31:0]                  io_base;
        logic [31:0]                  io_limit;
        logic [31:0]                  mem_base;
        logic [31:0]                  mem_limit;
        logic [31:0]                  pref_base;
        logic [31:0]                  pref_limit;
        logic [bridge_pkg::IRQ_W-1:0] irq_status;
        logic [bridge_pkg::IRQ_W-1:0] irq_mask;
        logic [31:0]                  rdata;
        logic [2:0]                   serr_sync;
        logic                         serr_level;
        logic                         syserr;
        logic                         parity_rep;
        logic                         fwd_valid;
        logic                         poison;
        bridge_pkg::resp_s            dn;
        bridge_pkg::resp_s            up;
    } state_s;

    state_s state_reg;
    state_s state_next;

    // the map needs 6 address bits; wider addresses would alias onto the low offsets
    if (ADDR_W < 6 || ADDR_W > 8) begin : g_addr_w_check
        $error("ADDR_W must be 6 to 8 bits for the register map");
    end

    // ==================================================
    // decode helpers
    function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    function automatic logic legacy_mem_hit(input logic [31:0] a);
        legacy_mem_hit = in_range(a, bridge_pkg::VIDEO_MEM_LO, bridge_pkg::VIDEO_MEM_HI);
    endfunction : legacy_mem_hit

    function automatic logic legacy_io_hit(input logic [31:0] a, input logic full);
        logic low_ok;
        low_ok = ((a[9:0] >= bridge_pkg::VIDEO_IO_A_LO) && (a[9:0] <= bridge_pkg::VIDEO_IO_A_HI)) ||
                 ((a[9:0] >= bridge_pkg::VIDEO_IO_B_LO) && (a[9:0] <= bridge_pkg::VIDEO_IO_B_HI));
        legacy_io_hit = (a[31:16] == 16'h0000) && low_ok && (!full || (a[15:10] == 6'h00));
    endfunction : legacy_io_hit

    // upper 768 bytes of a 1 KB block inside the first 64 KB
    function automatic logic alias_hit(input logic [31:0] a);
        alias_hit = (a[31:16] == 16'h0000) && (a[9:8] != 2'h0);
    endfunction : alias_hit

    // ==================================================
    // register file view
    logic video_en;
    logic full_decode;
    logic alias_en;
    logic io_en;
    logic mem_en;
    logic [7:0] wide_addr;

    assign video_en    = state_reg.bc[bridge_pkg::BC_VIDEO_BIT];
    // the full decode bit is only consulted through video_en paths
    assign full_decode = state_reg.bc[bridge_pkg::BC_FULL_BIT] & video_en;
    assign alias_en    = state_reg.bc[bridge_pkg::BC_ALIAS_BIT];
    assign io_en       = state_reg.cmd[bridge_pkg::CMD_IO_BIT];
    assign mem_en      = state_reg.cmd[bridge_pkg::CMD_MEM_BIT];
    assign wide_addr   = 8'(reg_addr);

    // ==================================================
    // forwarding decisions
    logic dn_video;
    logic dn_in_io;
    logic dn_in_mem;
    logic dn_fwd;
    logic up_video;
    logic up_in_io;
    logic up_in_mem;
    logic up_fwd;

    always_comb begin
        dn_in_io  = in_range(dn_req.addr, state_reg.io_base, state_reg.io_limit);
        dn_in_mem = in_range(dn_req.addr, state_reg.mem_base, state_reg.mem_limit) ||
                    in_range(dn_req.addr, state_reg.pref_base, state_reg.pref_limit);
        dn_video  = video_en && (dn_req.is_io ? legacy_io_hit(dn_req.addr, full_decode)
                                              : legacy_mem_hit(dn_req.addr));
        if (dn_video) begin
            // windows and alias block are bypassed here
            dn_fwd = dn_req.is_io ? io_en : mem_en;
        end else if (dn_req.is_io) begin
            dn_fwd = io_en && dn_in_io && !(alias_en && alias_hit(dn_req.addr));
        end else begin
            dn_fwd = mem_en && dn_in_mem;
        end
    end

    always_comb begin
        up_in_io  = in_range(up_req.addr, state_reg.io_base, state_reg.io_limit);
        up_in_mem = in_range(up_req.addr, state_reg.mem_base, state_reg.mem_limit) ||
                    in_range(up_req.addr, state_reg.pref_base, state_reg.pref_limit);
        up_video  = video_en && (up_req.is_io ? legacy_io_hit(up_req.addr, full_decode)
                                              : legacy_mem_hit(up_req.addr));
        if (up_video) begin
            up_fwd = 1'b0;
        end else if (up_req.is_io) begin
            // aliased IO_ALIAS_BLOCK_EN ranges inside the window belong upstream
            up_fwd = (alias_en && up_in_io && alias_hit(up_req.addr)) || !up_in_io;
        end else begin
            up_fwd = !up_in_mem;
        end
    end

    // ==================================================
    // next state
    logic serr_on;
    logic any_err;
    logic [bridge_pkg::IRQ_W-1:0] irq_set;

    always_comb begin
        state_next = state_reg;
        serr_on    = 1'b0;
        any_err    = 1'b0;
        irq_set    = '0;

        // pin synchroniser; only the agreeing later stages are looked at
        state_next.serr_sync = {state_reg.serr_sync[1:0], sec_serr_n};
        if (state_reg.serr_sync[1] == state_reg.serr_sync[2]) begin
            state_next.serr_level = !state_reg.serr_sync[2];
        end

        serr_on = state_reg.bc[bridge_pkg::BC_SYSERR_BIT] &&
                  state_reg.cmd[bridge_pkg::CMD_SERR_BIT] && state_reg.serr_level;
        state_next.syserr = serr_on;

        any_err = sec_addr_err || sec_attr_err || sec_data_err;
        state_next.parity_rep = state_reg.bc[bridge_pkg::BC_PARITY_BIT] && any_err;

        // poison is independent of the parity response bit
        state_next.fwd_valid = up_data_valid;
        state_next.poison    = up_data_valid && sec_data_err;

        state_next.dn = '{valid: dn_req.valid, forward: dn_req.valid && dn_fwd};
        state_next.up = '{valid: up_req.valid, forward: up_req.valid && up_fwd};

        irq_set[bridge_pkg::IRQ_SYSERR] = serr_on && !state_reg.syserr;
        irq_set[bridge_pkg::IRQ_PARITY] = state_next.parity_rep;
        irq_set[bridge_pkg::IRQ_POISON] = state_next.poison;

        state_next.rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (wide_addr)
                bridge_pkg::OFS_BRIDGE_CONTROL: state_next.rdata = 32'(state_reg.bc);
                bridge_pkg::OFS_COMMAND:        state_next.rdata = 32'(state_reg.cmd);
                bridge_pkg::OFS_IO_BASE:        state_next.rdata = state_reg.io_base;
                bridge_pkg::OFS_IO_LIMIT:       state_next.rdata = state_reg.io_limit;
                bridge_pkg::OFS_MEM_BASE:       state_next.rdata = state_reg.mem_base;
                bridge_pkg::OFS_MEM_LIMIT:      state_next.rdata = state_reg.mem_limit;
                bridge_pkg::OFS_PREF_BASE:      state_next.rdata = state_reg.pref_base;
                bridge_pkg::OFS_PREF_LIMIT:     state_next.rdata = state_reg.pref_limit;
                bridge_pkg::OFS_IRQ_STATUS:     state_next.rdata = 32'(state_reg.irq_status);
                bridge_pkg::OFS_IRQ_MASK:       state_next.rdata = 32'(state_reg.irq_mask);
                default:                        state_next.rdata = 32'h0000_0000;
            endcase
        end

        // a read clears status, but an event in the same cycle survives
        if (reg_rd && (wide_addr == bridge_pkg::OFS_IRQ_STATUS)) begin
            state_next.irq_status = irq_set;
        end else begin
            state_next.irq_status = state_reg.irq_status | irq_set;
        end

        if (reg_wr) begin
            case (wide_addr)
                bridge_pkg::OFS_BRIDGE_CONTROL: state_next.bc = reg_wdata[bridge_pkg::BC_W-1:0];
                bridge_pkg::OFS_COMMAND:        state_next.cmd = reg_wdata[bridge_pkg::CMD_W-1:0];
                bridge_pkg::OFS_IO_BASE:        state_next.io_base = reg_wdata;
                bridge_pkg::OFS_IO_LIMIT:       state_next.io_limit = reg_wdata;
                bridge_pkg::OFS_MEM_BASE:       state_next.mem_base = reg_wdata;
                bridge_pkg::OFS_MEM_LIMIT:      state_next.mem_limit = reg_wdata;
                bridge_pkg::OFS_PREF_BASE:      state_next.pref_base = reg_wdata;
                bridge_pkg::OFS_PREF_LIMIT:     state_next.pref_limit = reg_wdata;
                bridge_pkg::OFS_IRQ_MASK:       state_next.irq_mask = reg_wdata[bridge_pkg::IRQ_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg            <= '0;
            state_reg.bc         <= bridge_pkg::BC_RESET;
            state_reg.cmd        <= bridge_pkg::CMD_RESET;
            state_reg.io_base    <= bridge_pkg::WIN_BASE_RESET;
            state_reg.io_limit   <= bridge_pkg::WIN_LIMIT_RESET;
            state_reg.mem_base   <= bridge_pkg::WIN_BASE_RESET;
            state_reg.mem_limit  <= bridge_pkg::WIN_LIMIT_RESET;
            state_reg.pref_base  <= bridge_pkg::WIN_BASE_RESET;
            state_reg.pref_limit <= bridge_pkg::WIN_LIMIT_RESET;
            state_reg.serr_sync  <= 3'h7;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==================================================
    // outputs
    assign reg_rdata         = state_reg.rdata;
    assign dn_resp           = state_reg.dn;
    assign up_resp           = state_reg.up;
    assign pri_syserr        = state_reg.syserr;
    assign parity_err_report = state_reg.parity_rep;
    assign up_data_fwd_valid = state_reg.fwd_valid;
    assign up_data_poison    = state_reg.poison;
    assign irq               = |(state_reg.irq_status & state_reg.irq_mask);

    // ==================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    video_mem_fwd_a: assert property (
        dn_req.valid && !dn_req.is_io && video_en && mem_en && legacy_mem_hit(dn_req.addr)
        |=> dn_resp.valid && dn_resp.forward)
        else $error("legacy video memory not forwarded");

    video_io_fwd_a: assert property (
        dn_req.valid && dn_req.is_io && video_en && io_en && !full_decode &&
        dn_req.addr[31:16] == 16'h0000 && dn_req.addr[9:0] == 10'h3c0
        |=> dn_resp.forward)
        else $error("legacy video io not forwarded");

    full_decode_a: assert property (
        dn_req.valid && dn_req.is_io && video_en && full_decode && dn_req.addr[15:10] != 6'h00 &&
        !in_range(dn_req.addr, state_reg.io_base, state_reg.io_limit)
        |=> !dn_resp.forward)
        else $error("full decode accepted an alias");

    up_block_a: assert property (
        up_req.valid && video_en && !up_req.is_io && legacy_mem_hit(up_req.addr)
        |=> up_resp.valid && !up_resp.forward)
        else $error("legacy video forwarded upstream");

    cmd_gate_a: assert property (
        dn_req.valid && dn_req.is_io && !io_en |=> !dn_resp.forward)
        else $error("io forwarded with io space disabled");

    alias_block_a: assert property (
        dn_req.valid && dn_req.is_io && alias_en && !dn_video && alias_hit(dn_req.addr)
        |=> !dn_resp.forward)
        else $error("isa alias forwarded downstream");

    alias_up_a: assert property (
        up_req.valid && up_req.is_io && alias_en && !up_video && alias_hit(up_req.addr)
        |=> up_resp.forward)
        else $error("isa alias not forwarded upstream");

    alias_off_a: assert property (
        dn_req.valid && dn_req.is_io && !alias_en && io_en &&
        in_range(dn_req.addr, state_reg.io_base, state_reg.io_limit)
        |=> dn_resp.valid && dn_resp.forward)
        else $error("io inside window not forwarded");

    bc_readback_a: assert property (
        reg_rd && wide_addr == bridge_pkg::OFS_BRIDGE_CONTROL |=> reg_rdata == 32'($past(state_reg.bc)))
        else $error("bridge control read back wrong");

    syserr_gate_a: assert property (
        pri_syserr |-> $past(state_reg.bc[bridge_pkg::BC_SYSERR_BIT]) &&
        $past(state_reg.cmd[bridge_pkg::CMD_SERR_BIT]) && $past(state_reg.serr_level))
        else $error("system error forwarded without all enables");

    serr_latency_a: assert property (
        $fell(sec_serr_n) ##1 (!sec_serr_n && !state_reg.bc[bridge_pkg::BC_SYSERR_BIT]) [*6]
        |-> !pri_syserr)
        else $error("system error forwarded while disabled");

    parity_ignore_a: assert property (
        !state_reg.bc[bridge_pkg::BC_PARITY_BIT] |=> !parity_err_report)
        else $error("parity error reported while ignored");

    parity_report_a: assert property (
        state_reg.bc[bridge_pkg::BC_PARITY_BIT] && sec_attr_err |=> parity_err_report)
        else $error("parity error not reported");

    poison_a: assert property (
        up_data_valid && sec_data_err |=> up_data_fwd_valid && up_data_poison)
        else $error("data error not poisoned");

    cover_video_io_c:  cover property (dn_req.valid && dn_video && dn_req.is_io ##1 dn_resp.forward);
    cover_alias_up_c:  cover property (up_req.valid && alias_en ##1 up_resp.forward);
    cover_syserr_c:    cover property ($rose(pri_syserr) ##1 state_reg.irq_status[bridge_pkg::IRQ_SYSERR]);
    cover_alias_dn_c:  cover property (dn_req.valid && dn_req.is_io && alias_en && alias_hit(dn_req.addr) ##1 !dn_resp.forward);
    cover_poison_c:    cover property (up_data_poison && !state_reg.bc[bridge_pkg::BC_PARITY_BIT]);

endmodule : bridge_legacy_decode_error_ctrl

/* File: dv/secondary_bus_model.sv */
// ==================================================
// secondary bus controller model
module secondary_bus_model (
    input  wire logic        clock,
    output logic             sec_serr_n,
    output logic             sec_addr_err,
    output logic             sec_attr_err,
    output logic             sec_data_err,
    output logic             up_data_valid,
    output bridge_pkg::req_s up_req
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        sec_serr_n = 1'b1;
        {sec_addr_err, sec_attr_err, sec_data_err, up_data_valid} = 4'h0;
        up_req = '0;
    end

    // error line is pulled up, so a release reads high
    task automatic serr_hold(input logic low);
        @(posedge clock);
        sec_serr_n <= ~low;
    endtask : serr_hold

    // one beat: {addr err, attr err, data err, data valid}
    task automatic err_beat(input logic [3:0] e);
        @(posedge clock);
        {sec_addr_err, sec_attr_err, sec_data_err, up_data_valid} <= e;
        @(posedge clock);
        {sec_addr_err, sec_attr_err, sec_data_err, up_data_valid} <= 4'h0;
    endtask : err_beat

    // released request fields are inverted so stale values never match by luck
    task automatic send_up(input bridge_pkg::req_s r);
        @(posedge clock);
        up_req <= r;
        @(posedge clock);
        up_req <= '{valid: 1'b0, is_io: ~r.is_io, addr: ~r.addr};
    endtask : send_up
endmodule : secondary_bus_model

/* File: dv/test_bridge_legacy_decode_error_ctrl.sv */
`define check_eq(got, exp) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module test_bridge_legacy_decode_error_ctrl;
    timeunit 1ns;
    timeprecision 1ns;

    // ==================================================
    // signals and model state
    logic              clock;
    logic              rst_n;
    logic [7:0]        reg_addr;
    logic [31:0]       reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [31:0]       reg_rdata;
    bridge_pkg::req_s  dn_req;
    bridge_pkg::req_s  up_req;
    bridge_pkg::resp_s dn_resp;
    bridge_pkg::resp_s up_resp;
    logic              sec_serr_n;
    logic              sec_addr_err;
    logic              sec_attr_err;
    logic              sec_data_err;
    logic              up_data_valid;
    logic              up_data_fwd_valid;
    logic              up_data_poison;
    logic              pri_syserr;
    logic              parity_err_report;
    logic              irq;
    int                mismatches;
    int                cmp_count;
    int                seed;
    logic [31:0]       d;
    logic [31:0]       r;
    logic [31:0]       bc_m;
    logic [31:0]       cmd_m;
    logic [31:0]       win_m [6];
    logic [9:0]        io_tab [9] = '{10'h3af, 10'h3b0, 10'h3bb, 10'h3bc, 10'h3c0, 10'h3df, 10'h3e0, 10'h0ff, 10'h1f0};
    logic [31:0]       mem_tab [4] = '{32'h0009_ffff, 32'h000a_0000, 32'h000b_ffff, 32'h000c_0000};

    bridge_legacy_decode_error_ctrl bridge_legacy_decode_error_ctrl_i (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dn_req(dn_req), .dn_resp(dn_resp), .up_req(up_req),
        .up_resp(up_resp), .sec_serr_n(sec_serr_n), .sec_addr_err(sec_addr_err),
        .sec_attr_err(sec_attr_err), .sec_data_err(sec_data_err), .up_data_valid(up_data_valid),
        .up_data_fwd_valid(up_data_fwd_valid), .up_data_poison(up_data_poison),
        .pri_syserr(pri_syserr), .parity_err_report(parity_err_report), .irq(irq));

    secondary_bus_model secondary_bus_model_i (
        .clock(clock), .sec_serr_n(sec_serr_n), .sec_addr_err(sec_addr_err), .sec_attr_err(sec_attr_err),
        .sec_data_err(sec_data_err), .up_data_valid(up_data_valid), .up_req(up_req));

    // ==================================================
    // register port tasks, model shadows bridge control, command and window writes
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_wdata <= ~v;
        if (a == 8'h00) bc_m = v & 32'h0000_001f;
        if (a == 8'h04) cmd_m = v;
        if (a >= 8'h08 && a <= 8'h1c) win_m[(a - 8'h08) >> 2] = v;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    // ==================================================
    // forwarding model
    function automatic logic inw(input int k, input logic [31:0] a);
        return a >= win_m[2 * k] && a <= win_m[2 * k + 1];
    endfunction : inw

    function automatic logic fwd(input logic up, input logic io, input logic [31:0] a);
        logic vhit;
        logic ahit;
        vhit = io ? (a[31:16] == 16'h0 && (!bc_m[4] || a[15:10] == 6'h0) &&
               ((a[9:0] >= 10'h3b0 && a[9:0] <= 10'h3bb) || (a[9:0] >= 10'h3c0 && a[9:0] <= 10'h3df)))
             : (a >= 32'h000a_0000 && a <= 32'h000b_ffff);
        ahit = bc_m[2] && a[31:16] == 16'h0 && a[9:8] != 2'b00;
        if (bc_m[3] && vhit) return up ? 1'b0 : (io ? cmd_m[0] : cmd_m[1]);
        if (io) return up ? (!inw(0, a) || ahit) : (cmd_m[0] && inw(0, a) && !ahit);
        return up ? !(inw(1, a) || inw(2, a)) : (cmd_m[1] && (inw(1, a) || inw(2, a)));
    endfunction : fwd

    task automatic req(input logic io, input logic [31:0] a);
        bridge_pkg::req_s q;
        q = '{valid: 1'b1, is_io: io, addr: a};
        @(posedge clock);
        dn_req <= q;
        @(posedge clock);
        dn_req <= '{valid: 1'b0, is_io: ~io, addr: ~a};
        #1;
        `check_eq(dn_resp, {1'b1, fwd(1'b0, io, a)})
        secondary_bus_model_i.send_up(q);
        #1;
        `check_eq(up_resp, {1'b1, fwd(1'b1, io, a)})
    endtask : req

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // ==================================================
    // clock, watchdog and tests
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // runs take about 3300 cycles; a hang is cut at the 30k cycle budget
    initial begin
        #300000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        {mismatches, cmp_count, seed} = {32'h0, 32'h0, 32'h75ae};
        {rst_n, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        dn_req = '0;
        {bc_m, cmd_m} = '0;
        foreach (win_m[k]) win_m[k] = k[0] ? 32'h0 : 32'hffff_ffff;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        for (int k = 0; k < 11; k++) begin
            rd(8'(k * 4), d);
            `check_eq(d, (k >= 2 && k <= 6 && !k[0]) ? 32'hffff_ffff : 32'h0)
        end
        repeat (8) begin
            r = $random(seed);
            wr(8'h00, r);
            rd(8'h00, d);
            `check_eq(d, r & 32'h0000_001f)
        end
        $display("test registers done");
        repeat (40) begin
            wr(8'h00, $random(seed));
            wr(8'h04, $random(seed) & 32'h0000_0103);
            r = $random(seed);
            wr(8'h08, r & 32'h0001_8000);
            wr(8'h0c, (r & 32'h0001_8000) + 32'h0000_7fff);
            wr(8'h10, 32'h0009_0000 + (r & 32'h0003_0000));
            wr(8'h14, 32'h0009_ffff + (r & 32'h0003_0000));
            wr(8'h18, r[20] ? 32'h000b_8000 : 32'hffff_ffff);
            wr(8'h1c, 32'h000c_7fff);
            foreach (io_tab[j]) begin
                d = $random(seed);
                req(1'b1, {15'h0, d[1] & d[2], d[3] ? d[15:10] : 6'h0, io_tab[j]});
            end
            foreach (mem_tab[j]) req(1'b0, mem_tab[j]);
            req(1'b1, $random(seed) & 32'h0001_ffff);
            req(1'b0, 32'h0008_0000 + ($random(seed) & 32'h0007_ffff));
        end
        $display("test decode done");
        rd(8'h20, d);
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, {30'h0, i[0], 1'b0});
            wr(8'h04, {23'h0, i[1], 8'h03});
            secondary_bus_model_i.serr_hold(1'b1);
            repeat (8) @(posedge clock);
            #1;
            `check_eq(pri_syserr, i == 3)
            rd(8'h20, d);
            `check_eq(d, {31'h0, i == 3})
            secondary_bus_model_i.serr_hold(1'b0);
            repeat (8) @(posedge clock);
            #1;
            `check_eq(pri_syserr, 1'b0)
        end
        $display("test system error done");
        // mask holds only poison, so a parity report must not raise irq
        wr(8'h24, 32'h0000_0004);
        for (int i = 0; i < 8; i++) begin
            wr(8'h00, {31'h0, i[2]});
            rd(8'h20, d);
            secondary_bus_model_i.err_beat({i[1:0] == 0, i[1:0] == 1, i[1:0] == 2, i[1]});
            #1;
            `check_eq(parity_err_report, i[2] && i[1:0] != 3)
            `check_eq(up_data_fwd_valid, i[1])
            `check_eq(up_data_poison, i[1:0] == 2)
            `check_eq(irq, i[1:0] == 2)
            rd(8'h20, d);
            `check_eq(d, {29'h0, i[1:0] == 2, i[2] && i[1:0] != 3, 1'b0})
            `check_eq(irq, 1'b0)
        end
        $display("test parity and poison done");
        tally_and_finish();
    end
endmodule : test_bridge_legacy_decode_error_ctrl
